// *** rtl/ocwd_pkg.sv ***
// Constants for the oscillator configuration word decoder.
// Assumes a single system clock and a synchronous, active-high reset.
package ocwd_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_CONFIG_WORD = 4'h0;
    localparam logic [3:0] ADDR_DECODED = 4'h4;
    localparam logic [31:0] RESET_READ_DATA = 32'h0000_0000;
    localparam logic [31:0] RESERVED_ONES_MASK = 32'hffff_2828;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CKSM_MSB = 15;
    localparam int CKSM_LSB = 14;
    localparam int LSO_KIND_BIT = 12;
    localparam int CLKOUT_DIS_BIT = 10;
    localparam int MAIN_MODE_MSB = 9;
    localparam int MAIN_MODE_LSB = 8;
    localparam int TWO_SPEED_BIT = 7;
    localparam int LSO_EN_BIT = 6;
    localparam int PLL_REF_BIT = 4;
    localparam int SRC_MSB = 2;
    localparam int SRC_LSB = 0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MAIN_EXTERNAL_CLOCK = 2'h0,
        MAIN_STANDARD_CRYSTAL = 2'h1,
        MAIN_HIGH_SPEED_CRYSTAL = 2'h2,
        MAIN_OFF = 2'h3
    } ocwd_main_mode_t;

    typedef enum logic [2:0] {
        SRC_FAST_RC_DIV = 3'h0,
        SRC_PLL = 3'h1,
        SRC_MAIN_OSC = 3'h2,
        SRC_UNDEFINED = 3'h3,
        SRC_LOW_SPEED_OSC = 3'h4,
        SRC_LOW_POWER_RC = 3'h5
    } ocwd_clock_source_t;

endpackage : ocwd_pkg

// *** rtl/ocwd_source_decode.sv ***
// Reset clock source field decoder.
// Assumes the field is held stable by the caller.
`timescale 1ns/1ps
`default_nettype none
module ocwd_source_decode (
    // Raw field
    input wire logic [2:0] source_field,
    // Decoded choice
    output ocwd_pkg::ocwd_clock_source_t source_choice
);
    always_comb begin
        case (source_field)
            3'h0: source_choice = ocwd_pkg::SRC_FAST_RC_DIV;
            3'h1: source_choice = ocwd_pkg::SRC_PLL;
            3'h2: source_choice = ocwd_pkg::SRC_MAIN_OSC;
            3'h3: source_choice = ocwd_pkg::SRC_UNDEFINED;
            3'h4: source_choice = ocwd_pkg::SRC_LOW_SPEED_OSC;
            3'h5: source_choice = ocwd_pkg::SRC_LOW_POWER_RC;
            default: source_choice = ocwd_pkg::SRC_FAST_RC_DIV;
        endcase
    end
endmodule : ocwd_source_decode
`default_nettype wire

// *** rtl/ocwd_top.sv ***
// Oscillator configuration word decoder: captures the word during reset
// and presents the decoded oscillator settings as stable levels.
// Assumes the non-volatile word is valid on config_word while rst is high.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module ocwd_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Non-volatile configuration word
    input wire logic [31:0] config_word,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Decoded settings
    output logic clock_switch_enable,
    output logic fail_safe_monitor_enable,
    output logic low_speed_osc_crystal,
    output logic low_speed_osc_owns_pins,
    output logic sysclk_out_enable,
    output logic main_osc_enable,
    output ocwd_pkg::ocwd_main_mode_t main_osc_mode,
    output logic two_speed_startup_enable,
    output logic low_speed_osc_enable,
    output logic pll_ref_fast_rc,
    output ocwd_pkg::ocwd_clock_source_t reset_clock_source_choice,
    output logic source_undefined,
    output logic reserved_bits_error
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] word;
        logic [31:0] rdata;
        logic cksw;
        logic fscm;
        logic lso_xtal;
        logic clkout;
        logic main_en;
        ocwd_pkg::ocwd_main_mode_t mode;
        logic two_speed;
        logic lso_en;
        logic pll_frc;
        ocwd_pkg::ocwd_clock_source_t src;
        logic src_undef;
        logic resv_err;
    } ocwd_state_t;

    ocwd_state_t state;
    ocwd_state_t next_state;
    ocwd_pkg::ocwd_clock_source_t decoded_src;

    // Word seen by the decoder: live during reset, captured copy afterwards
    logic [31:0] word_view;
    assign word_view = rst ? config_word : state.word;

    ocwd_source_decode u_src (
        .source_field(word_view[ocwd_pkg::SRC_MSB:ocwd_pkg::SRC_LSB]),
        .source_choice(decoded_src)
    );

    function automatic logic [31:0] pack_decoded(input ocwd_state_t s);
        pack_decoded = 32'h0000_0000;
        pack_decoded[0] = s.cksw;
        pack_decoded[1] = s.fscm;
        pack_decoded[2] = s.lso_xtal;
        pack_decoded[3] = s.clkout;
        pack_decoded[4] = s.main_en;
        pack_decoded[6:5] = s.mode;
        pack_decoded[7] = s.two_speed;
        pack_decoded[8] = s.lso_en;
        pack_decoded[9] = s.pll_frc;
        pack_decoded[12:10] = s.src;
        pack_decoded[13] = s.src_undef;
        pack_decoded[14] = s.resv_err;
    endfunction : pack_decoded

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        // Capture only while reset is asserted; settings freeze afterwards
        if (rst) begin
            next_state.word = config_word;
            next_state.cksw = word_view[ocwd_pkg::CKSM_LSB];
            next_state.fscm = word_view[ocwd_pkg::CKSM_MSB];
            next_state.lso_xtal = word_view[ocwd_pkg::LSO_KIND_BIT];
            next_state.clkout = ~word_view[ocwd_pkg::CLKOUT_DIS_BIT];
            next_state.mode = ocwd_pkg::ocwd_main_mode_t'(
                word_view[ocwd_pkg::MAIN_MODE_MSB:ocwd_pkg::MAIN_MODE_LSB]);
            next_state.main_en = (next_state.mode != ocwd_pkg::MAIN_OFF);
            next_state.two_speed = word_view[ocwd_pkg::TWO_SPEED_BIT];
            next_state.lso_en = word_view[ocwd_pkg::LSO_EN_BIT];
            next_state.pll_frc = word_view[ocwd_pkg::PLL_REF_BIT];
            next_state.src = decoded_src;
            next_state.src_undef = (decoded_src == ocwd_pkg::SRC_UNDEFINED);
            // Flags a badly programmed word; decoding still proceeds
            next_state.resv_err = ((word_view & ocwd_pkg::RESERVED_ONES_MASK)
                != ocwd_pkg::RESERVED_ONES_MASK);
            next_state.rdata = ocwd_pkg::RESET_READ_DATA;
        end else begin
            // Writes are ignored: every setting is read-only
            next_state.rdata = ocwd_pkg::RESET_READ_DATA;
            if (reg_read) begin
                if (reg_addr == ocwd_pkg::ADDR_CONFIG_WORD) begin
                    next_state.rdata = state.word;
                end else if (reg_addr == ocwd_pkg::ADDR_DECODED) begin
                    next_state.rdata = pack_decoded(state);
                end else begin
                    next_state.rdata = ocwd_pkg::RESET_READ_DATA;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        state <= next_state;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata = state.rdata;
    assign clock_switch_enable = state.cksw;
    assign fail_safe_monitor_enable = state.fscm;
    assign low_speed_osc_crystal = state.lso_xtal;
    assign low_speed_osc_owns_pins = state.lso_xtal;
    assign sysclk_out_enable = state.clkout;
    assign main_osc_enable = state.main_en;
    assign main_osc_mode = state.mode;
    assign two_speed_startup_enable = state.two_speed;
    assign low_speed_osc_enable = state.lso_en;
    assign pll_ref_fast_rc = state.pll_frc;
    assign reset_clock_source_choice = state.src;
    assign source_undefined = state.src_undef;
    assign reserved_bits_error = state.resv_err;

    // Unused write path: data is accepted and dropped
    logic unused_write;
    assign unused_write = reg_write & (|reg_wdata);

endmodule : ocwd_top
`default_nettype wire

// *** verif/ocwd_properties.sv ***
// Port checker for the oscillator configuration word decoder.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module ocwd_properties (
    // Clock, reset and word
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [31:0] config_word,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // Decoded settings
    input wire logic clock_switch_enable,
    input wire logic fail_safe_monitor_enable,
    input wire logic low_speed_osc_crystal,
    input wire logic low_speed_osc_owns_pins,
    input wire logic sysclk_out_enable,
    input wire logic main_osc_enable,
    input wire ocwd_pkg::ocwd_main_mode_t main_osc_mode,
    input wire logic two_speed_startup_enable,
    input wire logic low_speed_osc_enable,
    input wire logic pll_ref_fast_rc,
    input wire ocwd_pkg::ocwd_clock_source_t reset_clock_source_choice,
    input wire logic source_undefined
);
    logic [31:0] cap;
    logic [2:0] src;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cap <= config_word;
        end
    end
    // Reserved top codes fall back to the divided fast RC choice
    assign src = (cap[2:1] == 2'h3) ? 3'h0 : cap[2:0];
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    sequence rd_word;
        reg_read && reg_addr == 4'h0;
    endsequence
    sequence settled;
        !$past(rst);
    endsequence
    chk_cksm_split: assert property (
        fail_safe_monitor_enable == cap[15] && clock_switch_enable == cap[14]) else $error("cksm");
    chk_lso_kind: assert property (
        low_speed_osc_crystal == cap[12] && low_speed_osc_owns_pins == cap[12]) else $error("lso");
    chk_clkout_pin: assert property (
        sysclk_out_enable == !cap[10]) else $error("clock out pin wrong");
    chk_main_mode: assert property (
        main_osc_mode == cap[9:8] && main_osc_enable == (cap[9:8] != 2'h3)) else $error("mode");
    chk_speed_lso_en: assert property (
        two_speed_startup_enable == cap[7] && low_speed_osc_enable == cap[6]) else $error("en");
    chk_pll_ref: assert property (
        pll_ref_fast_rc == cap[4]) else $error("pll reference wrong");
    chk_source_code: assert property (
        reset_clock_source_choice == src && source_undefined == (src == 3'h3)) else $error("src");
    chk_hold_stable: assert property (
        settled |-> $stable({reset_clock_source_choice, main_osc_mode, sysclk_out_enable}))
        else $error("settings moved");
    chk_read_word: assert property (
        rd_word |=> reg_rdata == cap) else $error("word readback wrong");
    chk_idle_zero: assert property (
        !reg_read |=> reg_rdata == 32'h0) else $error("read data not zero");
endmodule : ocwd_properties
bind ocwd_top ocwd_properties ocwd_properties_inst (.*);
`default_nettype wire

// *** verif/ocwd_nv_word.sv ***
// Stand-in for the non-volatile word and whoever programmed it.
// Assumes the bench sets the fields and may ask for a faulty word.
`timescale 1ns/1ps
`default_nettype none
module ocwd_nv_word (
    // Fields and fault request
    input wire logic [31:0] fields,
    input wire logic skip_reserved,
    // Word seen by the decoder
    output logic [31:0] config_word
);
    assign config_word = skip_reserved ? fields : (fields | 32'hffff_2828);
endmodule : ocwd_nv_word
`default_nettype wire

// *** verif/ocwd_top_tb.sv ***
// Self-checking bench for the oscillator configuration word decoder.
// Assumes the checker is bound to the top module.
`timescale 1ns/1ps
`default_nettype none
module ocwd_top_tb;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [31:0] fields = 32'h0;
    logic skip_reserved = 1'b0;
    logic [31:0] config_word;
    logic [3:0] reg_addr = 4'h0;
    logic reg_write = 1'b0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #20 clk_sys = ~clk_sys;
    ocwd_nv_word ocwd_nv_word_inst (.fields(fields), .skip_reserved(skip_reserved),
        .config_word(config_word));
    ocwd_top ocwd_top_inst (.clk_sys(clk_sys), .rst(rst), .config_word(config_word),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .clock_switch_enable(), .fail_safe_monitor_enable(),
        .low_speed_osc_crystal(), .low_speed_osc_owns_pins(), .sysclk_out_enable(),
        .main_osc_enable(), .main_osc_mode(), .two_speed_startup_enable(),
        .low_speed_osc_enable(), .pll_ref_fast_rc(), .reset_clock_source_choice(),
        .source_undefined(), .reserved_bits_error());
    function automatic logic [31:0] exp_dec(input logic [31:0] w);
        logic [2:0] s;
        s = (w[2:1] == 2'h3) ? 3'h0 : w[2:0];
        return {17'h0, (w | 32'h0000_d7d7) != 32'hffff_ffff, s == 3'h3, s, w[4], w[6], w[7],
            w[9:8], w[9:8] != 2'h3, ~w[10], w[12], w[15], w[14]};
    endfunction : exp_dec
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t read %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic boot(input logic [31:0] f);
        @(posedge clk_sys);
        fields <= f;
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
    endtask : boot
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        cmp(reg_rdata, e);
    endtask : rd
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_decode();
        logic [2:0] k;
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            boot({16'h0, k[1:0], 1'b0, k[0], 1'b0, k[1], k[1:0], k[0], k[1], 1'b0, k[2], 1'b0, k});
            rd(4'h4, exp_dec(config_word));
        end
    endtask : t_decode
    task automatic t_hold();
        logic [31:0] w;
        boot(32'h0000_4155);
        w = config_word;
        fields <= 32'h0000_beaa;
        // Writes of all ones to the decoded offset 4'h4 must leave every setting alone
        reg_wdata <= 32'hffff_ffff;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_addr <= 4'h4;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        reg_wdata <= 32'h0000_0000;
        reg_read <= 1'b1;
        reg_addr <= 4'h0;
        @(posedge clk_sys);
        reg_addr <= 4'h4;
        #1;
        cmp(reg_rdata, w);
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1;
        cmp(reg_rdata, exp_dec(w));
        rd(4'h8, 32'h0);
    endtask : t_hold
    task automatic t_fault();
        skip_reserved <= 1'b1;
        boot(32'h0000_0000);
        rd(4'h4, exp_dec(config_word));
        skip_reserved <= 1'b0;
    endtask : t_fault
    task automatic results();
        if (err_total == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys);
        t_decode();
        t_hold();
        t_fault();
        results();
    end
endmodule : ocwd_top_tb
`default_nettype wire
